// ### verilog/crcc_pkg.sv
// Constants, write-port struct and bit-order helpers for the byte-wise CRC engine.
// Assumes a single synchronous clock domain shared with the CPU side.
package crcc_pkg;

	localparam int          CRC_W      = 16;
	localparam int          DATA_W     = 8;
	localparam logic [15:0] CRC_POLY   = 16'h1021;  // Terms 16, 12, 5 and 0
	localparam logic [15:0] CRC_RST    = 16'h0000;
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam int          UPDATE_CYC = 2;

	typedef struct packed {
		logic              init_we;   // Write to crc_result_register
		logic [CRC_W-1:0]  init_val;  // Starting value, read order
		logic              byte_we;   // Write to crc_input_register
		logic [DATA_W-1:0] byte_val;  // Message byte as written
	} crcc_wr_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FOLD = 2'b10
	} crcc_state_t;

	function automatic logic [DATA_W-1:0] crcc_rev8(input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		r = '0;
		for (int i = 0; i < DATA_W; i++) begin
			r[i] = d[DATA_W-1-i];
		end
		return r;
	endfunction : crcc_rev8

	function automatic logic [CRC_W-1:0] crcc_rev16(input logic [CRC_W-1:0] d);
		logic [CRC_W-1:0] r;
		r = '0;
		for (int i = 0; i < CRC_W; i++) begin
			r[i] = d[CRC_W-1-i];
		end
		return r;
	endfunction : crcc_rev16

	// Remainder of (rem * x^8 + d * x^16) modulo the generator, MSB first
	function automatic logic [CRC_W-1:0] crcc_fold(input logic [CRC_W-1:0] rem, input logic [DATA_W-1:0] d);
		logic [CRC_W-1:0] c;
		c = rem ^ {d, 8'h00};
		for (int i = 0; i < DATA_W; i++) begin
			if (c[CRC_W-1]) begin
				c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[CRC_W-2:0], 1'b0};
			end
		end
		return c;
	endfunction : crcc_fold

endpackage : crcc_pkg

// ### verilog/crcc_engine.sv
// Byte-wise CRC engine with a loadable result and one input byte per update.
// Assumes the CPU side presents one-cycle write strobes synchronous to core_clk.
`timescale 1ns/100ps

module crcc_engine (
	input  wire logic                      core_clk,  // System clock, 250 MHz
	input  wire logic                      resetn,    // Asynchronous reset, active low
	input  wire crcc_pkg::crcc_wr_t        wr,        // CPU writes to both registers
	output logic [crcc_pkg::CRC_W-1:0]     result,    // crc_result_register read value
	output logic                           busy       // Update in progress
);
	import crcc_pkg::*;

	crcc_state_t       st_r;
	crcc_state_t       st_nxt;
	logic [CRC_W-1:0]  rem_r;
	logic [CRC_W-1:0]  rem_nxt;
	logic [DATA_W-1:0] byte_r;
	logic [DATA_W-1:0] byte_nxt;
	logic              accept;

	// A byte written mid-update is dropped; software is expected to pace itself
	assign accept = wr.byte_we && !wr.init_we && (st_r == ST_IDLE);

	always_comb begin
		st_nxt   = st_r;
		rem_nxt  = rem_r;
		byte_nxt = byte_r;
		case (st_r)
			ST_IDLE: begin
				if (accept) begin
					byte_nxt = wr.byte_val;
					st_nxt   = ST_FOLD;
				end
			end
			ST_FOLD: begin
				rem_nxt = crcc_fold(rem_r, crcc_rev8(byte_r));
				st_nxt  = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
		// Load wins and cancels a pending fold so the new start is not corrupted
		if (wr.init_we) begin
			rem_nxt = crcc_rev16(wr.init_val);
			st_nxt  = ST_IDLE;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r   <= ST_IDLE;
			rem_r  <= CRC_RST;
			byte_r <= BYTE_RST;
		end else begin
			st_r   <= st_nxt;
			rem_r  <= rem_nxt;
			byte_r <= byte_nxt;
		end
	end

	// Stored in division order; reads come out reversed
	// Plain wiring per bit, so the read path adds no logic depth
	generate
		for (genvar i = 0; i < CRC_W; i++) begin : g_rev
			assign result[i] = rem_r[CRC_W-1-i];
		end
	endgenerate

	assign busy = (st_r == ST_FOLD);

	poly_check_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_r == ST_FOLD && rem_r == 16'h0000 && byte_r == 8'h01 && !wr.init_we) |=> rem_r == 16'h9188)
		else $error("fold of 01h from zero is not 9188h");

	one_fold_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		accept |=> (st_r == ST_FOLD) ##1 (st_r == ST_IDLE))
		else $error("accepted byte did not give exactly one fold");

	init_load_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		wr.init_we |=> (result == $past(wr.init_val)) && !busy)
		else $error("starting value not readable after load");

	update_time_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		accept |=> busy ##1 !busy)
		else $error("byte update not done in two cycles");

	fold_math_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		accept ##1 !wr.init_we |=> rem_r == crcc_fold($past(rem_r, 2), crcc_rev8($past(wr.byte_val, 2))))
		else $error("remainder does not match reversed-byte division");

	carry_rev_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(busy && !wr.init_we) |=>
			result == crcc_rev16(crcc_fold(crcc_rev16($past(result)), crcc_rev8($past(byte_r)))))
		else $error("result is not reversed carried remainder");

	idle_hold_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(!busy && !accept && !wr.init_we) |=> $stable(result))
		else $error("result changed without a write");

	// Known vectors and control invariants below

	busy_pulse_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		busy |=> !busy)
		else $error("busy stood longer than one cycle");

	busy_refuse_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(busy && wr.byte_we) |=> $stable(byte_r))
		else $error("byte taken while an update was running");

	load_cancel_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(busy && wr.init_we) |=> !busy && (result == $past(wr.init_val)))
		else $error("load during update did not win");

	load_beats_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(wr.init_we && wr.byte_we) |=> !busy)
		else $error("byte started a fold beside a load");

	fold_wait_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		accept |=> $stable(result))
		else $error("result moved before the fold cycle");

	second_vec_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_r == ST_FOLD && rem_r == 16'h9188 && byte_r == 8'h23 && !wr.init_we) |=> rem_r == 16'h8250)
		else $error("fold of 23h onto 9188h is not 8250h");

	first_read_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_r == ST_FOLD && rem_r == 16'h0000 && byte_r == 8'h01 && !wr.init_we) |=> result == 16'h1189)
		else $error("read of first vector is not 1189h");

	second_read_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_r == ST_FOLD && rem_r == 16'h9188 && byte_r == 8'h23 && !wr.init_we) |=> result == 16'h0A41)
		else $error("read of second vector is not 0A41h");

	rev_ends_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(result[0] == rem_r[15]) && (result[15] == rem_r[0]))
		else $error("outer result bits not mirrored");

	rev_mid_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(result[7] == rem_r[8]) && (result[8] == rem_r[7]))
		else $error("middle result bits not mirrored");

	state_onehot_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		$onehot(st_r))
		else $error("state register not one-hot");

	byte_capture_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		accept |=> byte_r == $past(wr.byte_val))
		else $error("accepted byte not captured");

	byte_hold_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!accept |=> $stable(byte_r))
		else $error("byte register moved without a write");

	rem_idle_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_r == ST_IDLE && !wr.init_we) |=> $stable(rem_r))
		else $error("remainder moved while idle");

	no_spurious_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!accept |=> !busy)
		else $error("busy rose without an accepted byte");

	fold_done_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_r == ST_FOLD) |=> (st_r == ST_IDLE))
		else $error("fold state did not return to idle");

	load_value_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		wr.init_we |=> rem_r == crcc_rev16($past(wr.init_val)))
		else $error("load not stored in division order");

	load_idle_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		wr.init_we |=> (st_r == ST_IDLE))
		else $error("load left a fold pending");

	fold_entry_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_r == ST_FOLD) |-> ($past(st_r) == ST_IDLE))
		else $error("fold entered from fold");

	// Checked while reset is held, so no disable here
	reset_clear_a: assert property (
		@(posedge core_clk)
		!resetn |-> (result == 16'h0000) && !busy)
		else $error("outputs not cleared in reset");

endmodule : crcc_engine

// ### verification/crcc_engine_bench.sv
// Self-checking bench for the byte-wise CRC engine.
// Assumes crcc_pkg and crcc_engine are compiled ahead of it.
`timescale 1ns/100ps
module crcc_engine_bench;
	import crcc_pkg::*;
	logic        core_clk;
	logic        resetn;
	logic        busy;
	logic        busy_d;
	crcc_wr_t    wr;
	logic [15:0] result;
	logic [15:0] model;
	logic [15:0] exp_q[$];
	logic [31:0] lfsr;
	int          bad_count;
	int          num_checks;
	crcc_engine dut_u (.core_clk(core_clk), .resetn(resetn), .wr(wr), .result(result), .busy(busy));
	function automatic logic [15:0] rv(input logic [15:0] d);
		for (int i = 0; i < 16; i++) rv[i] = d[15-i];
	endfunction : rv
	// Own bitwise model, kept apart from the package helpers
	function automatic logic [15:0] fold(input logic [15:0] r, input logic [7:0] b);
		logic [15:0] c;
		c = rv(r) ^ (rv({8'h00, b}) & 16'hFF00);
		for (int i = 0; i < 8; i++) c = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0000);
		return rv(c);
	endfunction : fold
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("Error at %0t: got %h, expected %h", $time, seen, want);
		end
	endtask : check
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic put_byte(input logic [7:0] b, input bit taken, input int gap, input bit with_load);
		wr.byte_we = 1'b1;
		wr.byte_val = b;
		wr.init_we = with_load;
		if (taken) begin
			model = fold(model, b);
			exp_q.push_back(model);
		end
		@(negedge core_clk);
		wr.byte_we = 1'b0;
		wr.init_we = 1'b0;
		repeat (gap) @(negedge core_clk);
	endtask : put_byte
	// Result is due the cycle busy drops
	always @(negedge core_clk) begin
		if (busy_d === 1'b1 && busy === 1'b0) begin
			if (exp_q.size() == 0) check(result, ~result);
			else check(result, exp_q.pop_front());
		end
		busy_d = busy;
	end
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#8000;
		bad_count++;
		give_verdict();
	end
	initial begin
		wr = '0;
		resetn = 1'b0;
		busy_d = 1'b0;
		model = 16'h0000;
		lfsr = 32'h833b;
		repeat (20) @(negedge core_clk);
		resetn = 1'b1;
		put_byte(8'h01, 1, 1, 0);
		check(result, 16'h1189);
		put_byte(8'h23, 1, 1, 0);
		check(result, 16'h0A41);
		put_byte(8'h5A, 1, 0, 0);
		put_byte(8'hC3, 0, 1, 0);
		// Load wins over a byte in the same cycle
		wr.init_val = 16'hBEEF;
		model = 16'hBEEF;
		put_byte(8'h77, 0, 1, 1);
		for (int n = 0; n < 40; n++) begin
			lfsr = lfsr_next(lfsr);
			if (lfsr[15:12] == 4'h0) begin
				wr.init_val = lfsr[31:16];
				model = lfsr[31:16];
				put_byte(lfsr[7:0], 0, 1, 1);
			end
			put_byte(lfsr[7:0], 1, 1 + int'(lfsr[9:8]), 0);
		end
		repeat (4) @(negedge core_clk);
		check(16'(exp_q.size()), 16'h0000);
		give_verdict();
	end
endmodule : crcc_engine_bench
